// file: src/mpc_map.vh
`ifndef MPC_MAP_VH
`define MPC_MAP_VH
// register byte offsets on the apb bus
`define MPC_OFF_HOLD0     12'h000
`define MPC_OFF_HOLD1     12'h004
`define MPC_OFF_HOLD2     12'h008
`define MPC_OFF_STEP0     12'h00C
`define MPC_OFF_STEP1     12'h010
`define MPC_OFF_STEP2     12'h014
`define MPC_OFF_LIMIT     12'h018
`define MPC_OFF_WORK0     12'h01C
`define MPC_OFF_WORK1     12'h020
`define MPC_OFF_WORK2     12'h024
`define MPC_OFF_REFRESH   12'h028
`define MPC_OFF_ORIGIN    12'h02C
`define MPC_OFF_LOAD_X_COORDINATE_MASK     12'h030
`define MPC_OFF_LOAD_Y_COORDINATE_MASK     12'h034
`define MPC_OFF_CHIPSEL   12'h038
`define MPC_OFF_SHIFT     12'h03C
`define MPC_OFF_DEXT      12'h040
`define MPC_OFF_CTRL      12'h044
`define MPC_OFF_STATUS    12'h048
`define MPC_OFF_CS_ADDR   12'h04C
`define MPC_OFF_CS_LO     12'h050
`define MPC_OFF_CS_HI     12'h054
`define MPC_OFF_COORD_CMD 12'h058
// x in low half, y in high half of a pair register
`define MPC_X_LSB         0
`define MPC_Y_LSB         16
// control register bits
`define MPC_CTRL_RUN      0
// coordinate command fields
`define MPC_CMD_OP_LSB    0
`define MPC_CMD_SET_LSB   2
`define MPC_CMD_X_BIT     4
`define MPC_CMD_Y_BIT     5
// coordinate operations
`define MPC_OP_NONE       2'h0
`define MPC_OP_INC        2'h1
`define MPC_OP_DEC        2'h2
`define MPC_OP_LOAD       2'h3
// control word type bit: set for data-generator word
`define MPC_CW_TYPE_BIT   43
`endif

// file: src/mpc_ctrl_store.v
`timescale 1ns/100ps
`default_nettype none
// control store of microwords, one write port, one registered read port
module mpc_ctrl_store #(
  parameter AW = 6,
  parameter DW = 44
) (
  input  wire          pclk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // memory has no reset; contents are defined by loading
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // mpc_ctrl_store
`default_nettype wire

// file: src/mpc_coord_regs.v
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "mpc_map.vh"
// Operation
// - ten coordinate registers: holding, step, limit and working pairs.
// - three holding pairs keep initial x and y values.
// - three step pairs keep increment and decrement amounts.
// - one limit register holds maximum x and y.
// - three working pairs are modified during pattern execution.
// - control store entries are 44 bits, typed address or data word.
// - one write loads both values of a selected holding pair.
// - one write loads both values of a selected step pair.
// - refresh interval register is loadable and held.
// - storage origin register is loaded before execution.
// - separate x and y mask registers are loadable.
// - set-up values are loaded before the microprogram runs.
// - working x or y is incremented, decremented or loaded from holding.
module mpc_coord_regs #(
  parameter CW = 16,
  parameter CS_AW = 6
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         run_q,
  output reg  [CW-1:0] cur_x_q,
  output reg  [CW-1:0] cur_y_q,
  output reg         cw_is_data_q
);
  localparam NSET = 3;
  localparam DW = 2*CW;

  reg [DW-1:0] hold_q [0:NSET-1];
  reg [DW-1:0] step_q [0:NSET-1];
  reg [DW-1:0] work_q [0:NSET-1];
  reg [DW-1:0] limit_q;
  reg [31:0]   refresh_q;
  reg [31:0]   origin_q;
  reg [CW-1:0] load_x_coordinate_mask_q;
  reg [CW-1:0] load_y_coordinate_mask_q;
  reg [31:0]   chipsel_q;
  reg [31:0]   shift_q;
  reg          dext_q;
  reg [CS_AW-1:0] cs_addr_q;
  reg [31:0]   cs_lo_q;
  reg [1:0]    cur_set_q;
  reg          late_wr_q;

  wire access = psel & penable;
  // a request is decoded in its first access cycle, while pready is low
  wire first  = access & ~pready;
  wire wr_req = access & pwrite;
  // writes commit only at the edge that carries pready, so a command
  // word is applied once per transfer, not once per access cycle
  wire wr     = wr_req & pready;
  // set-up writes refused while running so patterns are not disturbed
  wire setup_ok = ~run_q;

  // pair register offset decode, shared by three register groups
  function [2:0] pair_hit;
    input [11:0] a;
    input [11:0] base;
    begin
      pair_hit[0] = (a == base);
      pair_hit[1] = (a == base + 12'h004);
      pair_hit[2] = (a == base + 12'h008);
    end
  endfunction

  wire [2:0] hold_hit = pair_hit(paddr, `MPC_OFF_HOLD0);
  wire [2:0] step_hit = pair_hit(paddr, `MPC_OFF_STEP0);
  wire [2:0] work_hit = pair_hit(paddr, `MPC_OFF_WORK0);

  wire cmd_wr = wr & (paddr == `MPC_OFF_COORD_CMD) & run_q;
  wire [1:0] cmd_op  = pwdata[`MPC_CMD_OP_LSB +: 2];
  wire [1:0] cmd_set = pwdata[`MPC_CMD_SET_LSB +: 2];
  wire       cmd_x   = pwdata[`MPC_CMD_X_BIT];
  wire       cmd_y   = pwdata[`MPC_CMD_Y_BIT];

  wire cs_wr = wr & setup_ok & (paddr == `MPC_OFF_CS_HI);
  wire [43:0] cs_rdata;

  mpc_ctrl_store #(.AW(CS_AW), .DW(44)) u_store (
    .pclk  (pclk),
    .we    (cs_wr),
    .waddr (cs_addr_q),
    .wdata ({pwdata[11:0], cs_lo_q}),
    .raddr (cs_addr_q),
    .rdata (cs_rdata)
  );

  // per-set registers: holding, step and working pairs
  genvar g;
  generate
    for (g = 0; g < NSET; g = g + 1) begin : g_set
      wire sel = cmd_wr & (cmd_set == g);
      wire [CW-1:0] wx = work_q[g][`MPC_X_LSB +: CW];
      wire [CW-1:0] wy = work_q[g][`MPC_Y_LSB +: CW];
      wire [CW-1:0] sx = step_q[g][`MPC_X_LSB +: CW];
      wire [CW-1:0] sy = step_q[g][`MPC_Y_LSB +: CW];
      wire [CW-1:0] hx = hold_q[g][`MPC_X_LSB +: CW];
      wire [CW-1:0] hy = hold_q[g][`MPC_Y_LSB +: CW];
      reg  [CW-1:0] nx;
      reg  [CW-1:0] ny;
      // working update by command
      always @* begin
        case (cmd_op)
          `MPC_OP_INC: begin
            nx = wx + sx;
            ny = wy + sy;
          end
          `MPC_OP_DEC: begin
            nx = wx - sx;
            ny = wy - sy;
          end
          `MPC_OP_LOAD: begin
            nx = hx;
            ny = hy;
          end
          default: begin
            nx = wx;
            ny = wy;
          end
        endcase
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hold_q[g] <= {DW{1'b0}};
          step_q[g] <= {DW{1'b0}};
          work_q[g] <= {DW{1'b0}};
        end else begin
          if (wr & setup_ok & hold_hit[g]) begin
            hold_q[g] <= pwdata[DW-1:0];
          end
          if (wr & setup_ok & step_hit[g]) begin
            step_q[g] <= pwdata[DW-1:0];
          end
          if (wr & setup_ok & work_hit[g]) begin
            work_q[g] <= pwdata[DW-1:0];
          end else if (sel) begin
            // x and y may move independently
            if (cmd_x) begin
              work_q[g][`MPC_X_LSB +: CW] <= nx;
            end
            if (cmd_y) begin
              work_q[g][`MPC_Y_LSB +: CW] <= ny;
            end
          end
        end
      end
    end
  endgenerate

  // one commit strobe per scalar set-up register
  wire setup_wr   = wr & setup_ok;
  wire limit_wr   = setup_wr & (paddr == `MPC_OFF_LIMIT);
  wire refresh_wr = setup_wr & (paddr == `MPC_OFF_REFRESH);
  wire origin_wr  = setup_wr & (paddr == `MPC_OFF_ORIGIN);
  wire load_x_coordinate_mask_wr   = setup_wr & (paddr == `MPC_OFF_LOAD_X_COORDINATE_MASK);
  wire load_y_coordinate_mask_wr   = setup_wr & (paddr == `MPC_OFF_LOAD_Y_COORDINATE_MASK);
  wire chipsel_wr = setup_wr & (paddr == `MPC_OFF_CHIPSEL);
  wire shift_wr   = setup_wr & (paddr == `MPC_OFF_SHIFT);
  wire dext_wr    = setup_wr & (paddr == `MPC_OFF_DEXT);
  wire csaddr_wr  = setup_wr & (paddr == `MPC_OFF_CS_ADDR);
  wire cslo_wr    = setup_wr & (paddr == `MPC_OFF_CS_LO);
  wire ctrl_wr    = wr & (paddr == `MPC_OFF_CTRL);
  wire status_wr  = wr & (paddr == `MPC_OFF_STATUS);

  // scalar set-up registers and run control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_q   <= {DW{1'b0}};
      refresh_q <= 32'h00000000;
      origin_q  <= 32'h00000000;
      load_x_coordinate_mask_q   <= {CW{1'b0}};
      load_y_coordinate_mask_q   <= {CW{1'b0}};
      chipsel_q <= 32'h00000000;
      shift_q   <= 32'h00000000;
      dext_q    <= 1'b0;
      cs_addr_q <= {CS_AW{1'b0}};
      cs_lo_q   <= 32'h00000000;
      run_q     <= 1'b0;
      cur_set_q <= 2'h0;
    end else begin
      if (limit_wr) begin
        limit_q <= pwdata[DW-1:0];
      end
      if (refresh_wr) begin
        refresh_q <= pwdata;
      end
      if (origin_wr) begin
        origin_q <= pwdata;
      end
      if (load_x_coordinate_mask_wr) begin
        load_x_coordinate_mask_q <= pwdata[CW-1:0];
      end
      if (load_y_coordinate_mask_wr) begin
        load_y_coordinate_mask_q <= pwdata[CW-1:0];
      end
      if (chipsel_wr) begin
        chipsel_q <= pwdata;
      end
      if (shift_wr) begin
        shift_q <= pwdata;
      end
      if (dext_wr) begin
        dext_q <= pwdata[0];
      end
      if (csaddr_wr) begin
        cs_addr_q <= pwdata[CS_AW-1:0];
      end
      if (cslo_wr) begin
        cs_lo_q <= pwdata;
      end
      // run bit always writable so software can stop a pattern
      if (ctrl_wr) begin
        run_q <= pwdata[`MPC_CTRL_RUN];
      end
      if (cmd_wr & (cmd_set < 2'h3)) begin
        cur_set_q <= cmd_set;
      end
    end
  end

  // read mux
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (paddr)
      `MPC_OFF_HOLD0:   rd_d[DW-1:0] = hold_q[0];
      `MPC_OFF_HOLD1:   rd_d[DW-1:0] = hold_q[1];
      `MPC_OFF_HOLD2:   rd_d[DW-1:0] = hold_q[2];
      `MPC_OFF_STEP0:   rd_d[DW-1:0] = step_q[0];
      `MPC_OFF_STEP1:   rd_d[DW-1:0] = step_q[1];
      `MPC_OFF_STEP2:   rd_d[DW-1:0] = step_q[2];
      `MPC_OFF_LIMIT:   rd_d[DW-1:0] = limit_q;
      `MPC_OFF_WORK0:   rd_d[DW-1:0] = work_q[0];
      `MPC_OFF_WORK1:   rd_d[DW-1:0] = work_q[1];
      `MPC_OFF_WORK2:   rd_d[DW-1:0] = work_q[2];
      `MPC_OFF_REFRESH: rd_d = refresh_q;
      `MPC_OFF_ORIGIN:  rd_d = origin_q;
      `MPC_OFF_LOAD_X_COORDINATE_MASK:   rd_d[CW-1:0] = load_x_coordinate_mask_q;
      `MPC_OFF_LOAD_Y_COORDINATE_MASK:   rd_d[CW-1:0] = load_y_coordinate_mask_q;
      `MPC_OFF_CHIPSEL: rd_d = chipsel_q;
      `MPC_OFF_SHIFT:   rd_d = shift_q;
      `MPC_OFF_DEXT:    rd_d[0] = dext_q;
      `MPC_OFF_CTRL:    rd_d[0] = run_q;
      `MPC_OFF_STATUS:  rd_d = {29'h00000000, late_wr_q, cur_set_q};
      `MPC_OFF_CS_ADDR: rd_d[CS_AW-1:0] = cs_addr_q;
      `MPC_OFF_CS_LO:   rd_d = cs_rdata[31:0];
      `MPC_OFF_CS_HI:   rd_d[11:0] = cs_rdata[43:32];
      default:          rd_d = 32'h00000000;
    endcase
  end

  // unmapped offsets and refused set-up writes answer with an error
  wire mapped = (paddr <= `MPC_OFF_COORD_CMD) & (paddr[1:0] == 2'b00);
  wire setup_addr = (paddr != `MPC_OFF_CTRL) & (paddr != `MPC_OFF_STATUS)
                  & (paddr != `MPC_OFF_COORD_CMD);
  wire refused = wr_req & run_q & setup_addr;

  // one wait state: pready rises at the end of the first access cycle and drops after
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h00000000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      cur_x_q      <= {CW{1'b0}};
      cur_y_q      <= {CW{1'b0}};
      cw_is_data_q <= 1'b0;
      late_wr_q    <= 1'b0;
    end else begin
      // answer one cycle after the request is taken
      pready  <= first;
      pslverr <= first & (~mapped | refused);
      if (first & ~pwrite) begin
        prdata <= rd_d;
      end
      // sticky: set wins over a clearing write to the status word
      if (first & refused) begin
        late_wr_q <= 1'b1;
      end else if (status_wr) begin
        late_wr_q <= 1'b0;
      end
      // observed pair follows the set picked by the last command
      cur_x_q      <= work_q[cur_set_q][`MPC_X_LSB +: CW];
      cur_y_q      <= work_q[cur_set_q][`MPC_Y_LSB +: CW];
      cw_is_data_q <= cs_rdata[`MPC_CW_TYPE_BIT];
    end
  end
endmodule // mpc_coord_regs
`default_nettype wire

// file: testbench/mpc_coord_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "mpc_map.vh"
module mpc_chk #(
  parameter CW = 16
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          run_q,
  input wire logic [CW-1:0] cur_x_q,
  input wire logic [CW-1:0] cur_y_q,
  input wire logic          cw_is_data_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // first access cycle, answer still owed
  sequence s_take;
    psel && penable && !pready;
  endsequence
  chk_one_wait: assert property (s_take |=> pready)
    else $error("access not answered after one wait");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error outside answer");
  chk_bad_addr: assert property (s_take ##0 (paddr > 12'h058 || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("bad address accepted");
  chk_setup_refused: assert property (s_take ##0 (run_q && pwrite && paddr < `MPC_OFF_CTRL)
    |=> pslverr)
    else $error("set-up write accepted while running");
  chk_idle_accept: assert property (s_take ##0 (!run_q && paddr <= 12'h058 && paddr[1:0] == 2'h0)
    |=> !pslverr)
    else $error("mapped access refused while idle");
  chk_run_bit: assert property (s_take ##0 (pwrite && paddr == `MPC_OFF_CTRL)
    |=> ##1 run_q == $past(pwdata[0]))
    else $error("run bit not loaded");
  chk_cmd_zero: assert property (s_take ##0 (!pwrite && paddr == `MPC_OFF_COORD_CMD)
    |=> prdata == 32'h0)
    else $error("command register read not zero");
  chk_cmd_idle: assert property (s_take ##0 (pwrite && !run_q && paddr == `MPC_OFF_COORD_CMD)
    |=> ($stable(cur_x_q) && $stable(cur_y_q)) [*2])
    else $error("idle command moved working pair");
endmodule // mpc_chk
bind mpc_coord_regs mpc_chk #(.CW(CW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .run_q(run_q), .cur_x_q(cur_x_q), .cur_y_q(cur_y_q),
  .cw_is_data_q(cw_is_data_q));
`default_nettype wire

// file: testbench/mpc_host_bfm.sv
`timescale 1ns/100ps
`default_nettype none
// apb requester standing in for the test controller
module mpc_host_bfm (
  input  wire logic        pclk,
  input  wire logic        pready,
  output var  logic        psel = 1'b0,
  output var  logic        penable = 1'b0,
  output var  logic        pwrite = 1'b0,
  output var  logic [11:0] paddr = 12'h0,
  output var  logic [31:0] pwdata = 32'h0
);
  // whole pair word per access, so x and y land in one operation
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    // released address and data lines flip so stale values never pass as data
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // mpc_host_bfm
`default_nettype wire

// file: testbench/test_mpc_coord_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "mpc_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_mpc_coord_regs;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  wire         psel, penable, pwrite, pready, pslverr, run_q, cw_is_data_q;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  wire  [15:0] cur_x_q, cur_y_q;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [64:0] notes[$];
  logic [64:0] n;
  logic [31:0] d, h, s;
  always #2 pclk = ~pclk;
  mpc_coord_regs #(.CW(16), .CS_AW(6)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_q(run_q), .cur_x_q(cur_x_q),
    .cur_y_q(cur_y_q), .cw_is_data_q(cw_is_data_q));
  mpc_host_bfm host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task tally_and_finish;
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // note the answer first, the watcher pops it when ready comes
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] m, input logic [31:0] e, input logic er);
    notes.push_back({er, m, e});
    host.xfer(w, a, wd);
  endtask
  // let registered outputs land before looking
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // watcher: every answer matched against the oldest note
  always @(posedge pclk) if (pready === 1'b1) begin
    if (notes.size() == 0) `CHK(1'b1, 1'b0)
    else begin
      n = notes.pop_front();
      `CHK(pslverr, n[64])
      `CHK(prdata & n[63:32], n[31:0])
    end
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    d = $urandom(32'h154c4629);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    `CHK({run_q, cur_x_q, cur_y_q}, 33'h0)
    for (int i = 0; i < 10; i++) begin
      d = $urandom;
      bus(1'b1, 12'(4 * i), d, 32'h0, 32'h0, 1'b0);
      bus(1'b0, 12'(4 * i), 32'h0, 32'hFFFFFFFF, d, 1'b0);
    end
    for (int a = `MPC_OFF_REFRESH; a <= `MPC_OFF_LOAD_Y_COORDINATE_MASK; a += 4) begin
      d = $urandom & 32'hFF;
      bus(1'b1, 12'(a), d, 32'h0, 32'h0, 1'b0);
      bus(1'b0, 12'(a), 32'h0, 32'hFF, d, 1'b0);
    end
    bus(1'b0, 12'h05C, 32'h0, 32'h0, 32'h0, 1'b1);
    bus(1'b1, 12'h001, 32'h1, 32'h0, 32'h0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      h = {20'h0, k[0], 11'h0};
      bus(1'b1, `MPC_OFF_CS_ADDR, 32'(5 + k), 32'h0, 32'h0, 1'b0);
      bus(1'b1, `MPC_OFF_CS_LO, $urandom, 32'h0, 32'h0, 1'b0);
      bus(1'b1, `MPC_OFF_CS_HI, h, 32'h0, 32'h0, 1'b0);
      bus(1'b0, `MPC_OFF_CS_HI, 32'h0, 32'hFFF, h, 1'b0);
      settle;
      `CHK(cw_is_data_q, k[0])
    end
    h = $urandom;
    s = $urandom;
    bus(1'b1, `MPC_OFF_HOLD1, h, 32'h0, 32'h0, 1'b0);
    bus(1'b1, `MPC_OFF_STEP1, s, 32'h0, 32'h0, 1'b0);
    bus(1'b1, `MPC_OFF_CTRL, 32'h1, 32'h0, 32'h0, 1'b0);
    bus(1'b1, `MPC_OFF_HOLD0, s, 32'h0, 32'h0, 1'b1);
    bus(1'b1, `MPC_OFF_COORD_CMD, 32'h37, 32'h0, 32'h0, 1'b0);
    settle;
    `CHK({cur_y_q, cur_x_q}, h)
    bus(1'b1, `MPC_OFF_COORD_CMD, 32'h15, 32'h0, 32'h0, 1'b0);
    bus(1'b1, `MPC_OFF_COORD_CMD, 32'h26, 32'h0, 32'h0, 1'b0);
    bus(1'b0, `MPC_OFF_COORD_CMD, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0);
    settle;
    `CHK(cur_x_q, h[15:0] + s[15:0])
    `CHK(cur_y_q, h[31:16] - s[31:16])
    bus(1'b0, `MPC_OFF_STATUS, 32'h0, 32'h7, 32'h5, 1'b0);
    bus(1'b1, `MPC_OFF_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
    bus(1'b1, `MPC_OFF_COORD_CMD, 32'h15, 32'h0, 32'h0, 1'b0);
    settle;
    `CHK(cur_x_q, h[15:0] + s[15:0])
    tally_and_finish;
  end
endmodule // test_mpc_coord_regs
`default_nettype wire
